// ==== common/cam_params.svh ====
// offsets, field positions, reset values and masks of the counter array block
`ifndef CAM_PARAMS_SVH
`define CAM_PARAMS_SVH

`define CAM_OFF_CTRL0      8'h00
`define CAM_OFF_CTRL1      8'h01
`define CAM_OFF_STATUS     8'h02
`define CAM_OFF_CNT0_LO    8'h03
`define CAM_OFF_CNT0_HI    8'h04
`define CAM_OFF_CNT1_LO    8'h05
`define CAM_OFF_CNT1_HI    8'h06
`define CAM_MOD_BLK0       5'h02
`define CAM_FLD_MODE       3'h0
`define CAM_FLD_CMP_LO     3'h1
`define CAM_FLD_CMP_HI     3'h2
`define CAM_FLD_CAP_LO     3'h3
`define CAM_FLD_CAP_HI     3'h4

`define CAM_MODE_IRQ_EN    7
`define CAM_MODE_COMP_EN   6
`define CAM_MODE_CAP_RISE  5
`define CAM_MODE_CAP_FALL  4
`define CAM_MODE_MATCH     3
`define CAM_MODE_TOGGLE    2
`define CAM_MODE_PWM_HI    1
`define CAM_MODE_PWM_LO    0

`define CAM_CTRL_ALL       7
`define CAM_CTRL_RUN       6
`define CAM_CTRL_OVF_IE    5
`define CAM_CTRL_TEN       2
`define CAM_CTRL0_MASK     8'hF7
`define CAM_CTRL1_MASK     8'h77

`define CAM_ST_OVF0        3
`define CAM_ST_OVF1        7
`define CAM_ST_GRP1        3

`define CAM_RST_BYTE       8'h00
`define CAM_RST_WORD       16'h0000
`define CAM_CNT_TOP        16'hFFFF

`endif

// ==== common/cam_pkg.sv ====
// types shared by the counter array block
package cam_pkg;

    localparam int unsigned CAM_N_MOD = 6;

    typedef enum logic [1:0] {
        CAM_PWM_OFF  = 2'h0,
        CAM_PWM_8F   = 2'h1,
        CAM_PWM_8P   = 2'h2,
        CAM_PWM_WIDE = 2'h3
    } cam_pwm_t;

    typedef enum logic [2:0] {
        CAM_FN_NOP,
        CAM_FN_PWM8F,
        CAM_FN_PWM8P,
        CAM_FN_PWMW,
        CAM_FN_TOGGLE,
        CAM_FN_TIMER,
        CAM_FN_CAPTURE
    } cam_fn_t;

endpackage

// ==== design/cam_module.sv ====
// one compare/capture/pwm module of the counter array
`timescale 1ns/1ps
`default_nettype none
`include "cam_params.svh"

module cam_module
    import cam_pkg::*;
#(
    parameter int unsigned CNT_W = 16
) (
    input  wire logic             sys_clk,
    input  wire logic             rst_b,
    input  wire logic             clk_en,
    input  wire logic [7:0]       mode,
    input  wire logic [CNT_W-1:0] cmp_val,
    input  wire logic [CNT_W-1:0] cnt,
    input  wire logic             cnt_run,
    input  wire logic             ten_bit_select,
    input  wire logic             module_pin_in,
    output logic                  flag_event,
    output logic [CNT_W-1:0]      cap_q,
    output logic                  pin_q,
    output logic                  pin_oe_b_q
);

    if (CNT_W < 16) begin : g_bad_width
        $error("cam_module: CNT_W below 16 cannot hold the period byte");
    end

    cam_pwm_t   pwm_sel;
    cam_fn_t    fn;
    logic       prev_q;
    logic [7:0] sub_q;

    assign pwm_sel = cam_pwm_t'(mode[`CAM_MODE_PWM_HI:`CAM_MODE_PWM_LO]);
    wire logic comp_en     = mode[`CAM_MODE_COMP_EN];
    wire logic cap_rise_en = mode[`CAM_MODE_CAP_RISE];
    wire logic cap_fall_en = mode[`CAM_MODE_CAP_FALL];
    wire logic match_en    = mode[`CAM_MODE_MATCH];
    wire logic toggle_en   = mode[`CAM_MODE_TOGGLE];
    // capture only with match, toggle and pwm all clear
    wire logic cap_mode = (cap_rise_en | cap_fall_en) & ~match_en & ~toggle_en
                          & (pwm_sel == CAM_PWM_OFF);

    assign fn = cap_mode                   ? CAM_FN_CAPTURE :
                (pwm_sel == CAM_PWM_8F)    ? CAM_FN_PWM8F :
                (pwm_sel == CAM_PWM_8P)    ? CAM_FN_PWM8P :
                (pwm_sel == CAM_PWM_WIDE)  ? CAM_FN_PWMW :
                (comp_en & match_en & toggle_en) ? CAM_FN_TOGGLE :
                (comp_en & match_en)       ? CAM_FN_TIMER : CAM_FN_NOP;

    wire logic is_pwm = (fn == CAM_FN_PWM8F) | (fn == CAM_FN_PWM8P) | (fn == CAM_FN_PWMW);
    wire logic cmp_hit = comp_en & cnt_run & (cnt == cmp_val)
                         & (pwm_sel == CAM_PWM_OFF) & ~cap_mode;
    wire logic tog_hit = cmp_hit & (fn == CAM_FN_TOGGLE);
    wire logic pin_rise = module_pin_in & ~prev_q;
    wire logic pin_fall = ~module_pin_in & prev_q;
    wire logic cap_hit = cap_mode & ((cap_rise_en & pin_rise)
                         | (cap_fall_en & pin_fall));
    assign flag_event = (cmp_hit & match_en) | cap_hit;

    wire logic [7:0] sub_nxt = (sub_q >= cmp_val[15:8]) ? 8'h00 : sub_q + 8'h01;
    wire logic wide_lvl = ten_bit_select ? (cnt[9:0] < cmp_val[9:0])
                                         : (cnt < cmp_val);
    wire logic pwm_lvl = (fn == CAM_FN_PWM8F) ? (cnt[7:0] < cmp_val[7:0]) :
                         (fn == CAM_FN_PWM8P) ? (sub_q < cmp_val[7:0]) : wide_lvl;
    wire logic pin_d = is_pwm ? pwm_lvl : (tog_hit ? ~pin_q : pin_q);

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            prev_q     <= 1'b0;
            sub_q      <= `CAM_RST_BYTE;
            cap_q      <= `CAM_RST_WORD;
            pin_q      <= 1'b0;
            pin_oe_b_q <= 1'b1;
        end else if (clk_en) begin
            prev_q     <= module_pin_in;
            if (fn == CAM_FN_PWM8P && cnt_run) begin
                sub_q <= sub_nxt;
            end
            if (cap_hit) begin
                cap_q <= cnt;
            end
            pin_q      <= pin_d;
            pin_oe_b_q <= ~(is_pwm | (fn == CAM_FN_TOGGLE));
        end
    end

    a_capture_latch: assert property (@(posedge sys_clk) disable iff (!rst_b)
        clk_en && cap_hit |=> cap_q == $past(cnt))
        else $error("capture did not latch the counter");

    a_comp_gate: assert property (@(posedge sys_clk) disable iff (!rst_b)
        !comp_en && !cap_mode |-> !flag_event)
        else $error("event with comparator disabled");

    a_toggle_invert: assert property (@(posedge sys_clk) disable iff (!rst_b)
        clk_en && tog_hit |=> pin_q != $past(pin_q))
        else $error("toggle match did not invert the pin");

    a_wide_pwm: assert property (@(posedge sys_clk) disable iff (!rst_b)
        clk_en && fn == CAM_FN_PWMW && ten_bit_select && cnt[9:0] < cmp_val[9:0]
        |=> pin_q && !pin_oe_b_q)
        else $error("10-bit pwm level wrong");

endmodule
`default_nettype wire

// ==== design/cam_top.sv ====
// counter array: two counters, six modules, status flags and merged interrupt
//
// Contract
// - eight sources, six module and two rollover, ORed into one interrupt.
// - mode bit 7 lets the module flag raise the interrupt.
// - mode bit 6 enables the comparator; off means no match events.
// - mode bit 5 captures the counter on a rising pin edge.
// - mode bit 4 captures the counter on a falling pin edge.
// - capture needs match, toggle and pwm clear; capture is 16 bits.
// - mode bit 3 makes a match set the flag; software timer.
// - mode bit 2 inverts the pin on match, with compare and match set.
// - pwm field 01 gives fixed-frequency 8-bit pwm on the pin.
// - pwm field 10 gives 8-bit pwm with programmable period.
// - pwm field 11 gives fixed-frequency 10 or 16-bit pwm.
// - mode registers reset to 00h, meaning no operation.
// - module flag set by hardware, held until software clears it.
// - rollover flag set on wrap, interrupts only when enabled.
// - pwm field 11 is 16-bit with select 0, 10-bit with select 1.
// - status bits: flags 0-2, rollover 0, flags 3-5, rollover 1.
//
// The implementer's own choices: strobed register access and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "cam_params.svh"

module cam_top
    import cam_pkg::*;
(
    input  wire logic                 sys_clk,
    input  wire logic                 rst_b,
    input  wire logic                 clk_en,
    input  wire logic [7:0]           reg_addr,
    input  wire logic [7:0]           reg_wdata,
    input  wire logic                 reg_wr,
    input  wire logic                 reg_rd,
    output logic      [7:0]           reg_rdata_q,
    input  wire logic [CAM_N_MOD-1:0] module_pin_in,
    output logic      [CAM_N_MOD-1:0] module_pin_out_q,
    output logic      [CAM_N_MOD-1:0] module_pin_oe_b_q,
    output logic                      array_irq_q
);

    logic [CAM_N_MOD-1:0][7:0]  mode_q;
    logic [CAM_N_MOD-1:0][15:0] cmp_q;
    logic [CAM_N_MOD-1:0][15:0] cap_val;
    logic [CAM_N_MOD-1:0][7:0]  mod_rdata;
    logic [CAM_N_MOD-1:0]       mod_event;
    logic [CAM_N_MOD-1:0]       wr_mode;
    logic [CAM_N_MOD-1:0]       wr_cmp_lo;
    logic [CAM_N_MOD-1:0]       wr_cmp_hi;
    logic [7:0]                 ctrl0_q;
    logic [7:0]                 ctrl1_q;
    logic [7:0]                 status_q;
    logic [7:0]                 status_d;
    logic [15:0]                cnt0_q;
    logic [15:0]                cnt1_q;
    logic [7:0]                 set_vec;
    logic [7:0]                 ien_vec;
    logic [7:0]                 clr_vec;
    logic [7:0]                 mod_rd_any;
    logic [7:0]                 rd_mux;

    // register write decode
    wire logic wr_ctrl0  = reg_wr & (reg_addr == `CAM_OFF_CTRL0);
    wire logic wr_ctrl1  = reg_wr & (reg_addr == `CAM_OFF_CTRL1);
    wire logic wr_status = reg_wr & (reg_addr == `CAM_OFF_STATUS);

    // the all-run bit of array 0 starts both counters together
    wire logic run0 = ctrl0_q[`CAM_CTRL_RUN] | ctrl0_q[`CAM_CTRL_ALL];
    wire logic run1 = ctrl1_q[`CAM_CTRL_RUN] | ctrl0_q[`CAM_CTRL_ALL];
    wire logic wrap0 = run0 & (cnt0_q == `CAM_CNT_TOP);
    wire logic wrap1 = run1 & (cnt1_q == `CAM_CNT_TOP);
    wire logic ten0 = ctrl0_q[`CAM_CTRL_TEN];
    wire logic ten1 = ctrl1_q[`CAM_CTRL_TEN];

    // rollover sources in their status positions
    assign set_vec[`CAM_ST_OVF0] = wrap0;
    assign set_vec[`CAM_ST_OVF1] = wrap1;
    assign ien_vec[`CAM_ST_OVF0] = ctrl0_q[`CAM_CTRL_OVF_IE];
    assign ien_vec[`CAM_ST_OVF1] = ctrl1_q[`CAM_CTRL_OVF_IE];

    for (genvar g = 0; g < CAM_N_MOD; g++) begin : g_mod
        // modules 0-2 sit below the first rollover bit, 3-5 above it
        localparam int unsigned POS = (g < `CAM_ST_GRP1) ? g : g + 1;
        localparam logic [4:0] BLK = `CAM_MOD_BLK0 + 5'(g);
        wire logic blk_hit = (reg_addr[7:3] == BLK);
        wire logic [2:0] fld = reg_addr[2:0];

        assign wr_mode[g]   = reg_wr & blk_hit & (fld == `CAM_FLD_MODE);
        assign wr_cmp_lo[g] = reg_wr & blk_hit & (fld == `CAM_FLD_CMP_LO);
        assign wr_cmp_hi[g] = reg_wr & blk_hit & (fld == `CAM_FLD_CMP_HI);
        assign mod_rdata[g] = !blk_hit ? 8'h00 :
                              (fld == `CAM_FLD_MODE)   ? mode_q[g] :
                              (fld == `CAM_FLD_CMP_LO) ? cmp_q[g][7:0] :
                              (fld == `CAM_FLD_CMP_HI) ? cmp_q[g][15:8] :
                              (fld == `CAM_FLD_CAP_LO) ? cap_val[g][7:0] :
                              (fld == `CAM_FLD_CAP_HI) ? cap_val[g][15:8] : 8'h00;

        assign set_vec[POS] = mod_event[g];
        assign ien_vec[POS] = mode_q[g][`CAM_MODE_IRQ_EN];

        cam_module #(
            .CNT_W (16)
        ) u_mod (
            .sys_clk        (sys_clk),
            .rst_b          (rst_b),
            .clk_en         (clk_en),
            .mode           (mode_q[g]),
            .cmp_val        (cmp_q[g]),
            .cnt            ((g < `CAM_ST_GRP1) ? cnt0_q : cnt1_q),
            .cnt_run        ((g < `CAM_ST_GRP1) ? run0 : run1),
            .ten_bit_select ((g < `CAM_ST_GRP1) ? ten0 : ten1),
            .module_pin_in  (module_pin_in[g]),
            .flag_event     (mod_event[g]),
            .cap_q          (cap_val[g]),
            .pin_q          (module_pin_out_q[g]),
            .pin_oe_b_q     (module_pin_oe_b_q[g])
        );
    end

    always_comb begin
        mod_rd_any = 8'h00;
        for (int i = 0; i < CAM_N_MOD; i++) begin
            mod_rd_any = mod_rd_any | mod_rdata[i];
        end
    end

    // register read select; unmapped addresses read zero
    assign rd_mux = (reg_addr == `CAM_OFF_CTRL0)   ? ctrl0_q :
                    (reg_addr == `CAM_OFF_CTRL1)   ? ctrl1_q :
                    (reg_addr == `CAM_OFF_STATUS)  ? status_q :
                    (reg_addr == `CAM_OFF_CNT0_LO) ? cnt0_q[7:0] :
                    (reg_addr == `CAM_OFF_CNT0_HI) ? cnt0_q[15:8] :
                    (reg_addr == `CAM_OFF_CNT1_LO) ? cnt1_q[7:0] :
                    (reg_addr == `CAM_OFF_CNT1_HI) ? cnt1_q[15:8] : mod_rd_any;

    // writing 0 clears a flag; a same-cycle event wins over the clear
    assign clr_vec  = wr_status ? ~reg_wdata : 8'h00;
    assign status_d = (status_q & ~clr_vec) | set_vec;

    wire logic pending_any = |(status_q & ien_vec);

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            mode_q <= '0;
            cmp_q  <= '0;
        end else if (clk_en) begin
            for (int i = 0; i < CAM_N_MOD; i++) begin
                if (wr_mode[i]) begin
                    mode_q[i] <= reg_wdata;
                end
                if (wr_cmp_lo[i]) begin
                    cmp_q[i][7:0] <= reg_wdata;
                end
                if (wr_cmp_hi[i]) begin
                    cmp_q[i][15:8] <= reg_wdata;
                end
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            ctrl0_q <= `CAM_RST_BYTE;
            ctrl1_q <= `CAM_RST_BYTE;
        end else if (clk_en) begin
            if (wr_ctrl0) begin
                ctrl0_q <= reg_wdata & `CAM_CTRL0_MASK;
            end
            if (wr_ctrl1) begin
                ctrl1_q <= reg_wdata & `CAM_CTRL1_MASK;
            end
        end
    end

    // counters wrap freely; a compare at the top value still hits once
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt0_q <= `CAM_RST_WORD;
            cnt1_q <= `CAM_RST_WORD;
        end else if (clk_en) begin
            if (run0) begin
                cnt0_q <= cnt0_q + 16'h0001;
            end
            if (run1) begin
                cnt1_q <= cnt1_q + 16'h0001;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            status_q    <= `CAM_RST_BYTE;
            array_irq_q <= 1'b0;
        end else if (clk_en) begin
            status_q    <= status_d;
            array_irq_q <= pending_any;
        end
    end

    // read data stands only in the cycle after the strobe
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            reg_rdata_q <= `CAM_RST_BYTE;
        end else if (clk_en) begin
            reg_rdata_q <= reg_rd ? rd_mux : 8'h00;
        end
    end

    a_irq_merge: assert property (@(posedge sys_clk) disable iff (!rst_b)
        clk_en |=> array_irq_q == $past(|(status_q & ien_vec)))
        else $error("merged interrupt does not follow enabled flags");

    a_irq_enable: assert property (@(posedge sys_clk) disable iff (!rst_b)
        clk_en && status_q[0] && mode_q[0][`CAM_MODE_IRQ_EN] |=> array_irq_q)
        else $error("enabled module flag did not interrupt");

    a_flag_sticky: assert property (@(posedge sys_clk) disable iff (!rst_b)
        clk_en |=> ($past(status_q) & ~$past(clr_vec) & ~status_q) == 8'h00)
        else $error("status flag dropped without a software clear");

    a_flag_set: assert property (@(posedge sys_clk) disable iff (!rst_b)
        clk_en && set_vec != 8'h00 |=> (status_q & $past(set_vec)) == $past(set_vec))
        else $error("hardware event did not set its status bit");

    a_wrap_flag: assert property (@(posedge sys_clk) disable iff (!rst_b)
        clk_en && run0 && cnt0_q == `CAM_CNT_TOP
        |=> status_q[`CAM_ST_OVF0] && cnt0_q == 16'h0000)
        else $error("rollover flag missing after counter wrap");

    a_wrap_masked: assert property (@(posedge sys_clk) disable iff (!rst_b)
        clk_en && (status_q & ien_vec) == 8'h00 |=> !array_irq_q)
        else $error("interrupt without an enabled pending flag");

    a_reset_nop: assert property (@(posedge sys_clk) disable iff (!rst_b)
        clk_en && mode_q[0] == 8'h00 ##1 mode_q[0] == 8'h00
        |-> module_pin_oe_b_q[0] && !mod_event[0])
        else $error("idle module drives its pin or raises events");

    a_read_data: assert property (@(posedge sys_clk) disable iff (!rst_b)
        clk_en && reg_rd && reg_addr == `CAM_OFF_STATUS |=> reg_rdata_q == $past(status_q))
        else $error("status read returned wrong data");

endmodule
`default_nettype wire

// ==== tb/tb_top.sv ====
// self-checking bench for the counter array: mode decode, flags and merged interrupt
`timescale 1ns/1ps
`default_nettype none

module tb_top
    import cam_pkg::*;
;
    logic                 sys_clk;
    logic                 rst_b;
    logic                 clk_en;
    logic [7:0]           reg_addr;
    logic [7:0]           reg_wdata;
    logic                 reg_wr;
    logic                 reg_rd;
    logic [7:0]           reg_rdata_q;
    logic [CAM_N_MOD-1:0] module_pin_in;
    logic [CAM_N_MOD-1:0] module_pin_out_q;
    logic [CAM_N_MOD-1:0] module_pin_oe_b_q;
    logic                 array_irq_q;
    int                   fails;
    int                   n_compared;

    cam_top cam_top_inst (
        .sys_clk           (sys_clk),
        .rst_b             (rst_b),
        .clk_en            (clk_en),
        .reg_addr          (reg_addr),
        .reg_wdata         (reg_wdata),
        .reg_wr            (reg_wr),
        .reg_rd            (reg_rd),
        .reg_rdata_q       (reg_rdata_q),
        .module_pin_in     (module_pin_in),
        .module_pin_out_q  (module_pin_out_q),
        .module_pin_oe_b_q (module_pin_oe_b_q),
        .array_irq_q       (array_irq_q)
    );

    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end

    task automatic test_done();
        $display("compared %0d, mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // one-cycle strobes; the next call waits for a fresh edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr    <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd   <= 1'b0;
        #1;
        d = reg_rdata_q;
    endtask

    task automatic wait_flag(input logic [7:0] m, input int lim);
        logic [7:0] d;
        int         k;
        d = 8'h00;
        k = 0;
        while ((d & m) !== m && k < lim) begin
            rd(8'h02, d);
            k++;
        end
        if ((d & m) !== m) begin
            fails++;
            $display("Error at %0t: flag wait got %h expected %h", $time, d, m);
            test_done();
        end
    endtask

    task automatic count_hi(input int n, output int c);
        c = 0;
        repeat (n) begin
            @(posedge sys_clk);
            #1;
            c += (module_pin_out_q[2] === 1'b1) ? 1 : 0;
        end
    endtask

    logic [7:0]  d;
    logic [7:0]  lo;
    logic [7:0]  hi;
    int          c;
    // capture table: mode, flag on rising, flag on falling
    logic [7:0]  cap_mode [4] = '{8'h20, 8'h10, 8'h30, 8'h28};
    logic        cap_rise [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
    logic        cap_fall [4] = '{1'b0, 1'b1, 1'b1, 1'b0};
    // pwm table: mode, compare lo, compare hi, ctrl0, window, expected high cycles
    logic [7:0]  pw_mode [4] = '{8'h41, 8'h42, 8'h43, 8'h43};
    logic [7:0]  pw_lo   [4] = '{8'h80, 8'h01, 8'h00, 8'h00};
    logic [7:0]  pw_hi   [4] = '{8'h00, 8'h03, 8'h83, 8'h83};
    logic [7:0]  pw_ctl  [4] = '{8'h40, 8'h40, 8'h40, 8'h44};
    int          pw_n    [4] = '{256, 256, 1024, 1024};
    int          pw_exp  [4] = '{128, 64, 1024, 768};

    initial begin
        fails = 0;
        n_compared = 0;
        rst_b = 1'b0;
        clk_en = 1'b1;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        module_pin_in = 6'h00;
        repeat (20) @(posedge sys_clk);
        rst_b <= 1'b1;

        for (int n = 0; n < 6; n++) begin
            rd(8'h10 + 8'(8 * n), d);
            check({8'h00, d}, 16'h0000);
            wr(8'h10 + 8'(8 * n), 8'hA5 ^ 8'(n));
            rd(8'h10 + 8'(8 * n), d);
            check({8'h00, d}, {8'h00, 8'hA5 ^ 8'(n)});
            wr(8'h10 + 8'(8 * n), 8'h00);
        end
        // settle past the edge that wrote the last mode
        #1;
        check({10'h000, module_pin_oe_b_q}, 16'h003F);
        check({15'h0000, array_irq_q}, 16'h0000);
        $display("test reset and mode registers done");

        // software timer with interrupt enabled
        wr(8'h11, 8'h40);
        wr(8'h12, 8'h00);
        wr(8'h10, 8'hC8);
        wr(8'h00, 8'h40);
        wait_flag(8'h01, 100);
        check({15'h0000, array_irq_q}, 16'h0001);
        repeat (4) @(posedge sys_clk);
        rd(8'h02, d);
        check({8'h00, d}, 16'h0001);
        wr(8'h02, 8'hFE);
        rd(8'h02, d);
        check({8'h00, d}, 16'h0000);
        check({15'h0000, array_irq_q}, 16'h0000);
        // flag without interrupt enable
        wr(8'h19, 8'h00);
        wr(8'h1A, 8'h02);
        wr(8'h18, 8'h48);
        wait_flag(8'h02, 400);
        check({15'h0000, array_irq_q}, 16'h0000);
        wr(8'h02, 8'h00);
        // comparator disabled: no match event
        wr(8'h21, 8'h00);
        wr(8'h22, 8'h03);
        wr(8'h20, 8'h88);
        repeat (1100) @(posedge sys_clk);
        rd(8'h02, d);
        check({8'h00, d}, 16'h0000);
        check({15'h0000, array_irq_q}, 16'h0000);
        wr(8'h00, 8'h00);
        $display("test timer and interrupt enable done");

        // capture with the counter stopped, so the latched value is known
        rd(8'h03, lo);
        rd(8'h04, hi);
        for (int i = 0; i < 4; i++) begin
            wr(8'h10, cap_mode[i]);
            @(posedge sys_clk);
            module_pin_in[0] <= 1'b1;
            repeat (3) @(posedge sys_clk);
            rd(8'h02, d);
            check({15'h0000, d[0]}, {15'h0000, cap_rise[i]});
            wr(8'h02, 8'h00);
            @(posedge sys_clk);
            module_pin_in[0] <= 1'b0;
            repeat (3) @(posedge sys_clk);
            rd(8'h02, d);
            check({15'h0000, d[0]}, {15'h0000, cap_fall[i]});
            wr(8'h02, 8'h00);
            if (cap_rise[i] || cap_fall[i]) begin
                rd(8'h13, d);
                check({8'h00, d}, {8'h00, lo});
                rd(8'h14, d);
                check({8'h00, d}, {8'h00, hi});
            end
        end
        $display("test capture edges done");

        // toggle on module 3, which reports in status bit 4
        wr(8'h29, 8'h08);
        wr(8'h2A, 8'h00);
        wr(8'h28, 8'h4C);
        wr(8'h08, 8'h40);
        wr(8'h01, 8'h40);
        #1;
        check({15'h0000, module_pin_oe_b_q[3]}, 16'h0000);
        check({15'h0000, module_pin_out_q[3]}, 16'h0000);
        wait_flag(8'h10, 100);
        check({15'h0000, module_pin_out_q[3]}, 16'h0001);
        wr(8'h02, 8'h00);
        $display("test toggle done");

        // rollover of counter 1: long wait, the only one in the run
        wr(8'h01, 8'h60);
        wait_flag(8'h80, 35000);
        check({15'h0000, array_irq_q}, 16'h0001);
        wr(8'h01, 8'h40);
        repeat (2) @(posedge sys_clk);
        #1;
        check({15'h0000, array_irq_q}, 16'h0000);
        rd(8'h02, d);
        check({15'h0000, d[7]}, 16'h0001);
        wr(8'h01, 8'h00);
        wr(8'h02, 8'h00);
        // start-both bit of control 0 runs counter 1 too: two edges, two counts
        rd(8'h05, lo);
        wr(8'h00, 8'h80);
        wr(8'h00, 8'h00);
        rd(8'h05, d);
        check({8'h00, d}, {8'h00, lo + 8'h02});
        $display("test rollover done");

        // pwm duty over whole periods, except the 16-bit case with 1024 cycles; window need not be phase aligned
        for (int i = 0; i < 4; i++) begin
            wr(8'h21, pw_lo[i]);
            wr(8'h22, pw_hi[i]);
            wr(8'h20, pw_mode[i]);
            wr(8'h00, pw_ctl[i]);
            repeat (8) @(posedge sys_clk);
            check({15'h0000, module_pin_oe_b_q[2]}, 16'h0000);
            count_hi(pw_n[i], c);
            check(16'(c), 16'(pw_exp[i]));
        end
        $display("test pwm modes done");
        test_done();
    end
endmodule

`default_nettype wire
